/* hdl/touch_baseline_control.sv */
// baseline tracking, nearness detection and apb registers
// Functional notes
// - after nearness clears, baseline updates wait (code+1)*8 update periods.
// - writing one to bit 28 restarts the conversion sequence at stage 0.
// - writing one to bit 27 forces calibration of all stages next sequence.
// - the fast filter takes a sample every 2*(code+1) conversion cycles.
// - quick nearness is flagged when stage vs average exceeds 4x threshold.
// - gradual nearness is flagged when baseline vs average exceeds 4x thr.
// - the slow filter weights each new sample by its code plus one.
// - the fast filter weights each new sample by its code plus one.
// - every field of the control register resets to zero.
`timescale 1ns/1ps
`include "touch_baseline_consts.svh"

module touch_baseline_control (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [31:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // conversion side
  input wire logic conv_valid,
  input wire touch_baseline_pkg::sample_t conv_sample,
  input wire logic seq_start,
  output logic conv_restart,
  output logic cal_all_stages,
  // detection results
  output logic quick_near,
  output logic gradual_near,
  output logic baseline_frozen,
  output logic [15:0] baseline_value,
  // interrupt
  output logic irq
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  // registers and their next values
  touch_baseline_pkg::ctrl_t ctrl_q;
  touch_baseline_pkg::ctrl_t ctrl_d;
  touch_baseline_pkg::ctrl_t wr_ctrl;
  touch_baseline_pkg::track_mode_t mode_q;
  touch_baseline_pkg::track_mode_t mode_d;
  logic [31:0] prdata_q;
  logic [31:0] rd_mux;
  logic [3:0] status_q;
  logic [3:0] status_d;
  logic [3:0] status_set;
  logic [3:0] status_clr;
  logic [3:0] mask_q;
  logic [3:0] conv_cnt_q;
  logic [3:0] conv_cnt_d;
  logic [6:0] hold_cnt_q;
  logic [6:0] hold_cnt_d;
  logic [6:0] hold_target;
  logic restart_q;
  logic force_q;
  logic force_d;
  logic cal_q;
  logic quick_q;
  logic gradual_q;
  logic [15:0] fast_value;
  logic [15:0] slow_value;
  // decode and datapath wires
  logic setup_ph;
  logic access_ph;
  logic hit_ctrl;
  logic hit_status;
  logic hit_mask;
  logic hit_base;
  logic hit_any;
  logic wr_ctrl_en;
  logic wr_mask_en;
  logic rd_status_en;
  logic tick;
  logic near_any;
  logic near_prev_q;
  logic slow_update;
  logic hold_done;
  logic [15:0] cmp_a [2];
  logic [15:0] cmp_b [2];
  logic [7:0] cmp_thr [2];
  logic [1:0] exceed;

  // ****************************************************************
  // apb decode
  // ****************************************************************
  // address match and phase qualifiers
  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable;
  assign hit_ctrl = (paddr == `BTC_ADDR);
  assign hit_status = (paddr == `EVT_STATUS_ADDR);
  assign hit_mask = (paddr == `EVT_MASK_ADDR);
  assign hit_base = (paddr == `BASELINE_READ_ADDR);
  assign hit_any = hit_ctrl | hit_status | hit_mask | hit_base;
  assign wr_ctrl_en = access_ph & pwrite & hit_ctrl;
  assign wr_mask_en = access_ph & pwrite & hit_mask;
  assign rd_status_en = access_ph & ~pwrite & hit_status;
  assign wr_ctrl = touch_baseline_pkg::ctrl_t'(pwdata);

  // zero wait state slave, unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = access_ph & ~hit_any;
  assign prdata = prdata_q;

  // read data selection, unused bits read as zero
  assign rd_mux = hit_ctrl ? 32'(ctrl_q) :
                  hit_status ? {28'h0000000, status_q} :
                  hit_mask ? {28'h0000000, mask_q} :
                  hit_base ? {16'h0000, slow_value} : 32'h0000_0000;

  // read data is captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup_ph) begin
      prdata_q <= rd_mux;
    end
  end

  // ****************************************************************
  // control register
  // ****************************************************************
  // next control value, command bits show the live request state
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl_en) begin
      ctrl_d = wr_ctrl;
    end
    ctrl_d.seq_restart = wr_ctrl_en & wr_ctrl.seq_restart;
    ctrl_d.force_cal = force_d;
  end

  // forced calibration stays pending until a sequence takes it
  assign force_d = (wr_ctrl_en & wr_ctrl.force_cal) |
                   (force_q & ~seq_start);

  // control storage, all fields zero out of reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= touch_baseline_pkg::ctrl_t'(`BTC_RESET);
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // command flops feeding the conversion side
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      restart_q <= 1'b0;
      force_q <= 1'b0;
      cal_q <= 1'b0;
    end else begin
      restart_q <= ctrl_d.seq_restart;
      force_q <= force_d;
      cal_q <= seq_start & force_q;
    end
  end

  // command pulses towards the conversion sequencer
  assign conv_restart = restart_q;
  assign cal_all_stages = cal_q;

  // ****************************************************************
  // fast filter update rate
  // ****************************************************************
  // tick once every 2*(code+1) conversions, restart realigns it
  assign tick = conv_valid &
                (conv_cnt_q == {ctrl_q.update_rate, 1'b1});
  assign conv_cnt_d = restart_q ? 4'h0 :
                      tick ? 4'h0 :
                      conv_valid ? conv_cnt_q + 4'h1 : conv_cnt_q;

  // conversion cycle counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_cnt_q <= 4'h0;
    end else begin
      conv_cnt_q <= conv_cnt_d;
    end
  end

  // ****************************************************************
  // tracking filters
  // ****************************************************************
  // fast filter follows the averaged result at the update rate
  tracker_filter u_fast (
    .pclk(pclk),
    .presetn(presetn),
    .seed(cal_q),
    .update(tick),
    .weight_code(ctrl_q.fast_tracker_weight),
    .sample(conv_sample.cap_to_digital_result),
    .value_q(fast_value)
  );

  // slow filter holds the baseline and follows the fast filter
  tracker_filter u_slow (
    .pclk(pclk),
    .presetn(presetn),
    .seed(cal_q),
    .update(slow_update),
    .weight_code(ctrl_q.slow_tracker_weight),
    .sample(fast_value),
    .value_q(slow_value)
  );

  // baseline updates only while tracking and nothing is near, a calibration seeds it in any mode
  assign slow_update = tick & (mode_q == touch_baseline_pkg::TRACK) &
                       ~near_any;
  assign baseline_value = slow_value;

  // ****************************************************************
  // nearness detection
  // ****************************************************************
  // channel 0 compares the stage result, channel 1 the baseline
  assign cmp_a[0] = conv_sample.stage_result;
  assign cmp_a[1] = slow_value;
  assign cmp_thr[0] = ctrl_q.quick_nearness_threshold;
  assign cmp_thr[1] = ctrl_q.gradual_nearness_threshold;
  assign cmp_b[0] = conv_sample.cap_to_digital_result;
  assign cmp_b[1] = conv_sample.cap_to_digital_result;

  // magnitude of the difference against four times the threshold
  for (genvar ch = 0; ch < 2; ch++) begin : g_cmp
    logic [15:0] mag;
    assign mag = (cmp_a[ch] > cmp_b[ch]) ? cmp_a[ch] - cmp_b[ch] :
                 cmp_b[ch] - cmp_a[ch];
    assign exceed[ch] = mag > {6'h00, cmp_thr[ch], 2'b00};
  end

  // flags refresh on each conversion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quick_q <= 1'b0;
      gradual_q <= 1'b0;
      near_prev_q <= 1'b0;
    end else begin
      if (conv_valid) begin
        quick_q <= exceed[0];
        gradual_q <= exceed[1];
      end
      near_prev_q <= near_any;
    end
  end

  // flag outputs and the combined nearness condition
  assign quick_near = quick_q;
  assign gradual_near = gradual_q;
  assign near_any = quick_q | gradual_q;

  // ****************************************************************
  // baseline freeze and holdoff
  // ****************************************************************
  // holdoff length is (code+1)*8 fast filter update periods
  assign hold_target = 7'({1'b0, ctrl_q.holdoff_code} + 4'h1)
                       << `HOLDOFF_SHIFT;
  assign hold_done = tick & (hold_cnt_q == hold_target - 7'h01);

  // freeze while near, then count out the holdoff
  always_comb begin
    mode_d = mode_q;
    hold_cnt_d = hold_cnt_q;
    case (mode_q)
      touch_baseline_pkg::TRACK: begin
        if (near_any) begin
          mode_d = touch_baseline_pkg::FROZEN;
        end
      end
      touch_baseline_pkg::FROZEN: begin
        hold_cnt_d = 7'h00;
        if (!near_any) begin
          mode_d = touch_baseline_pkg::HOLDOFF;
        end
      end
      touch_baseline_pkg::HOLDOFF: begin
        if (near_any) begin
          mode_d = touch_baseline_pkg::FROZEN;
        end else if (hold_done) begin
          mode_d = touch_baseline_pkg::TRACK;
        end else if (tick) begin
          hold_cnt_d = hold_cnt_q + 7'h01;
        end
      end
      default: begin
        mode_d = touch_baseline_pkg::TRACK;
      end
    endcase
  end

  // tracking mode and holdoff counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= touch_baseline_pkg::TRACK;
      hold_cnt_q <= 7'h00;
    end else begin
      mode_q <= mode_d;
      hold_cnt_q <= hold_cnt_d;
    end
  end

  // frozen covers both the freeze and the holdoff count
  assign baseline_frozen = (mode_q != touch_baseline_pkg::TRACK);

  // ****************************************************************
  // interrupt status and mask
  // ****************************************************************
  // sticky events, a read clears only the bits it returned
  assign status_set[`EVT_QUICK_BIT] = conv_valid & exceed[0] & ~quick_q;
  assign status_set[`EVT_GRADUAL_BIT] = conv_valid & exceed[1] &
                                        ~gradual_q;
  assign status_set[`EVT_CLEARED_BIT] = near_prev_q & ~near_any;
  assign status_set[`EVT_RESUMED_BIT] = (mode_q ==
                                         touch_baseline_pkg::HOLDOFF) &
                                        ~near_any & hold_done;
  assign status_clr = rd_status_en ? prdata_q[3:0] : 4'h0;
  assign status_d = (status_q & ~status_clr) | status_set;

  // status and mask storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= `EVT_RESET;
      mask_q <= `MASK_RESET;
    end else begin
      status_q <= status_d;
      if (wr_mask_en) begin
        mask_q <= pwdata[3:0];
      end
    end
  end

  // level interrupt while any unmasked event is pending
  assign irq = |(status_q & mask_q);

endmodule

/* hdl/touch_baseline_consts.svh */
// constants for the baseline tracking control block
`ifndef TOUCH_BASELINE_CONSTS_SVH
`define TOUCH_BASELINE_CONSTS_SVH

// ****************************************************************
// register byte addresses
// ****************************************************************
`define BTC_ADDR 32'h4008_4014
`define EVT_STATUS_ADDR 32'h4008_4100
`define EVT_MASK_ADDR 32'h4008_4104
`define BASELINE_READ_ADDR 32'h4008_4108

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define BTC_RESET 32'h0000_0000
`define BTC_RESTART_BIT 28
`define BTC_FORCE_CAL_BIT 27
`define EVT_RESET 4'h0
`define MASK_RESET 4'h0
`define EVT_QUICK_BIT 0
`define EVT_GRADUAL_BIT 1
`define EVT_CLEARED_BIT 2
`define EVT_RESUMED_BIT 3

// ****************************************************************
// timing counts
// ****************************************************************
// holdoff periods per delay code step is eight, a shift by three
`define HOLDOFF_SHIFT 3
`define SAMPLE_RESET 16'h0000

`endif

/* hdl/touch_baseline_pkg.sv */
// types shared by the baseline tracking control block
package touch_baseline_pkg;

  // ****************************************************************
  // control register layout
  // ****************************************************************
  typedef struct packed {
    logic [2:0] holdoff_code;
    logic seq_restart;
    logic force_cal;
    logic [2:0] update_rate;
    logic [7:0] quick_nearness_threshold;
    logic [7:0] gradual_nearness_threshold;
    logic [3:0] slow_tracker_weight;
    logic [3:0] fast_tracker_weight;
  } ctrl_t;

  // ****************************************************************
  // one conversion result
  // ****************************************************************
  typedef struct packed {
    logic [15:0] stage_result;
    logic [15:0] cap_to_digital_result;
  } sample_t;

  // ****************************************************************
  // baseline tracking modes
  // ****************************************************************
  typedef enum logic [1:0] {
    TRACK = 2'b00,
    FROZEN = 2'b01,
    HOLDOFF = 2'b10
  } track_mode_t;

endpackage

/* hdl/tracker_filter.sv */
// first order tracking filter with a programmable new sample weight
`timescale 1ns/1ps
`include "touch_baseline_consts.svh"

module tracker_filter (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic seed,
  input wire logic update,
  input wire logic [3:0] weight_code,
  // data
  input wire logic [15:0] sample,
  output logic [15:0] value_q
);

  logic signed [16:0] diff;
  logic signed [5:0] weight;
  logic signed [21:0] prod;
  logic signed [21:0] step;
  logic signed [16:0] sum;
  logic [15:0] value_d;

  // step toward the sample by weight/16 of the gap
  assign diff = $signed({1'b0, sample}) - $signed({1'b0, value_q});
  assign weight = $signed({2'b00, weight_code} + 6'h01); // up to 16
  assign prod = diff * weight;
  assign step = prod >>> 4;
  assign sum = $signed({1'b0, value_q}) + step[16:0];
  assign value_d = seed ? sample : (update ? sum[15:0] : value_q);

  // filter state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value_q <= `SAMPLE_RESET;
    end else begin
      value_q <= value_d;
    end
  end

endmodule

/* verification/baseline_monitor.sv */
// assertion checker for the baseline tracking control block
`timescale 1ns/1ps
`include "touch_baseline_consts.svh"

module baseline_monitor (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [31:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // conversion side
  input wire logic conv_valid,
  input wire touch_baseline_pkg::sample_t conv_sample,
  input wire logic seq_start,
  input wire logic conv_restart,
  input wire logic cal_all_stages,
  // detection results
  input wire logic quick_near,
  input wire logic gradual_near,
  input wire logic baseline_frozen,
  input wire logic [15:0] baseline_value,
  // interrupt
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ****************************************************************
  // helper logic
  // ****************************************************************
  logic [7:0] qthr_q;
  logic [7:0] gthr_q;
  wire logic wr = psel && penable && pwrite;
  wire logic btc = paddr == `BTC_ADDR;
  wire logic mapped = btc || paddr == `EVT_STATUS_ADDR ||
    paddr == `EVT_MASK_ADDR || paddr == `BASELINE_READ_ADDR;
  wire logic [15:0] st = conv_sample.stage_result;
  wire logic [15:0] av = conv_sample.cap_to_digital_result;
  wire logic [15:0] qd = st > av ? st - av : av - st;
  wire logic [15:0] gd = baseline_value > av ? baseline_value - av :
    av - baseline_value;
  wire logic qexp = qd > {6'h00, qthr_q, 2'h0};
  wire logic gexp = gd > {6'h00, gthr_q, 2'h0};

  // threshold shadow taken from control writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qthr_q <= 8'h00;
      gthr_q <= 8'h00;
    end else if (wr && btc) begin
      qthr_q <= pwdata[23:16];
      gthr_q <= pwdata[15:8];
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  ready_high_a: assert property (pready)
    else $error("pready low");
  unmapped_err_a: assert property (psel && penable && !mapped |->
    pslverr && prdata == 32'h0) else $error("unmapped not refused");
  mapped_ok_a: assert property (psel && penable && mapped |-> !pslverr)
    else $error("mapped access refused");
  restart_pulse_a: assert property (wr && btc && pwdata[28] |=>
    conv_restart ##1 !conv_restart) else $error("restart pulse");
  restart_cause_a: assert property (conv_restart |->
    $past(wr && btc && pwdata[28])) else $error("stray restart");
  cal_cause_a: assert property (cal_all_stages |-> $past(seq_start))
    else $error("stray calibration");
  quick_flag_a: assert property (conv_valid |=>
    quick_near == $past(qexp)) else $error("quick flag");
  gradual_flag_a: assert property (conv_valid |=>
    gradual_near == $past(gexp)) else $error("gradual flag");
  flag_hold_a: assert property (!conv_valid |=>
    $stable({quick_near, gradual_near})) else $error("flag moved");
  freeze_on_a: assert property (quick_near || gradual_near |->
    ##[0:1] baseline_frozen) else $error("not frozen");
  frozen_hold_a: assert property (baseline_frozen &&
    $past(baseline_frozen) && !$past(cal_all_stages) |->
    $stable(baseline_value)) else $error("baseline moved");
endmodule

bind touch_baseline_control baseline_monitor baseline_monitor_i (
  .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
  .prdata, .pready, .pslverr, .conv_valid, .conv_sample, .seq_start,
  .conv_restart, .cal_all_stages, .quick_near, .gradual_near,
  .baseline_frozen, .baseline_value, .irq
);

/* verification/touch_baseline_control_tb_top.sv */
// self-checking testbench for the baseline tracking control block
`timescale 1ns/1ps
`include "touch_baseline_consts.svh"

module touch_baseline_control_tb_top;
  logic pclk, presetn, psel, penable, pwrite, conv_valid, seq_start;
  logic [31:0] paddr, pwdata, prdata, rdata;
  logic pready, pslverr, rerr, conv_restart, cal_all_stages, irq;
  logic quick_near, gradual_near, baseline_frozen;
  logic [15:0] baseline_value;
  touch_baseline_pkg::sample_t conv_sample;
  int err_total, total_checks, restart_cnt, cal_cnt;

  touch_baseline_control touch_baseline_control_i (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .conv_valid, .conv_sample, .seq_start,
    .conv_restart, .cal_all_stages, .quick_near, .gradual_near,
    .baseline_frozen, .baseline_value, .irq
  );

  // ****************************************************************
  // clock, pulse counters, shared tasks
  // ****************************************************************
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // count command pulses mid-cycle, clear of the edge that launches them
  always @(negedge pclk) begin
    if (conv_restart === 1'b1) restart_cnt++;
    if (cal_all_stages === 1'b1) cal_cnt++;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one apb transfer, waits for pready; only the watchdog ends a hang
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // one conversion cycle, then time for flags and mode to settle
  task cv(input logic [15:0] s, input logic [15:0] v);
    conv_sample <= {s, v};
    conv_valid <= 1'b1;
    @(posedge pclk);
    conv_valid <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  task seq();
    seq_start <= 1'b1;
    @(posedge pclk);
    seq_start <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task t_reset();
    apb(1'b0, `BTC_ADDR, 32'h0);
    chk(rdata, `BTC_RESET);
    apb(1'b0, `EVT_STATUS_ADDR, 32'h0);
    chk(rdata, {28'h0, `EVT_RESET});
    apb(1'b0, `EVT_MASK_ADDR, 32'h0);
    chk(rdata, {28'h0, `MASK_RESET});
    apb(1'b0, 32'h4008_4200, 32'h0);
    chk(rerr, 1'b1);
    chk(rdata, 32'h0);
    chk(irq, 1'b0);
  endtask

  task t_fields();
    int n;
    apb(1'b1, `BTC_ADDR, 32'ha75a_3c96);
    apb(1'b0, `BTC_ADDR, 32'h0);
    chk(rdata, 32'ha75a_3c96);
    n = restart_cnt;
    apb(1'b1, `BTC_ADDR, 32'h1000_0000);
    chk(restart_cnt - n, 1);
    apb(1'b0, `BTC_ADDR, 32'h0);
    chk(rdata, 32'h0);
    apb(1'b1, `BTC_ADDR, 32'h0);
    chk(restart_cnt - n, 1);
  endtask

  task t_cal();
    int n;
    conv_sample <= {16'h1000, 16'h1000};
    n = cal_cnt;
    apb(1'b1, `BTC_ADDR, 32'h0810_0400);
    apb(1'b0, `BTC_ADDR, 32'h0);
    chk(rdata, 32'h0810_0400);
    chk(cal_cnt - n, 0);
    seq();
    chk(cal_cnt - n, 1);
    apb(1'b0, `BTC_ADDR, 32'h0);
    chk(rdata, 32'h0010_0400);
    seq();
    chk(cal_cnt - n, 1);
    // slow filter seeds from the fast value, so calibrate once more
    apb(1'b1, `BTC_ADDR, 32'h0810_0400);
    seq();
    chk(cal_cnt - n, 2);
    apb(1'b0, `BASELINE_READ_ADDR, 32'h0);
    chk(rdata, 32'h1000);
  endtask

  task t_near();
    apb(1'b1, `EVT_MASK_ADDR, 32'h8);
    cv(16'h1040, 16'h1000);
    chk({quick_near, gradual_near}, 2'h0);
    cv(16'h1041, 16'h1000);
    chk({quick_near, gradual_near}, 2'h2);
    chk(baseline_frozen, 1'b1);
    cv(16'h1051, 16'h1010);
    chk({quick_near, gradual_near}, 2'h2);
    cv(16'h1052, 16'h1011);
    chk({quick_near, gradual_near}, 2'h3);
    cv(16'h1030, 16'h0fef);
    chk({quick_near, gradual_near}, 2'h3);
    chk(baseline_value, 16'h1000);
    chk(irq, 1'b0);
  endtask

  // freeze, clear the flags, count conversions until tracking resumes
  task t_holdoff(input logic [31:0] cfg, input int exp,
                 input logic [3:0] evt);
    int n;
    apb(1'b1, `BTC_ADDR, cfg);
    cv(16'h1041, 16'h1000);
    apb(1'b1, `BTC_ADDR, cfg | 32'h1000_0000);
    n = 0;
    do begin
      cv(16'h1000, 16'h1000);
      n++;
    end while (baseline_frozen !== 1'b0 && n < 200);
    chk(n, exp);
    chk(irq, 1'b1);
    apb(1'b0, `EVT_STATUS_ADDR, 32'h0);
    chk(rdata, {28'h0, evt});
    chk(irq, 1'b0);
    apb(1'b0, `EVT_STATUS_ADDR, 32'h0);
    chk(rdata, 32'h0);
  endtask

  task t_weights();
    apb(1'b1, `BTC_ADDR, 32'h0010_ffff);
    repeat (4) cv(16'h1100, 16'h1100);
    chk(baseline_value, 16'h1100);
    apb(1'b1, `BTC_ADDR, 32'h0010_ff00);
    // unit weights: fast 1110, 111f, 112d, slow 1100, 1101, 1102, 1104
    repeat (8) cv(16'h1200, 16'h1200);
    chk(baseline_value, 16'h1104);
  endtask

  task end_sim();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    conv_valid = 1'b0;
    conv_sample = 32'h0;
    seq_start = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_fields();
    t_cal();
    t_near();
    t_holdoff(32'h0010_0400, 16, 4'hf);
    t_holdoff(32'h2110_0400, 64, 4'hd);
    t_weights();
    end_sim();
  end

  // cut a hang short well beyond the expected run time
  initial begin
    #200000;
    err_total++;
    end_sim();
  end
endmodule
